// *** sfcd_pkg.sv ***
// Package for the serial flash command decoder: opcodes, groups and command descriptors.
package sfcd_pkg;

  // ----------------------------------------------------------------
  // Single-byte opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_RD = 8'hD2;
  localparam logic [7:0] OP_CONT_LP = 8'h01;
  localparam logic [7:0] OP_CONT_LF = 8'h03;
  localparam logic [7:0] OP_CONT_HF0 = 8'h0B;
  localparam logic [7:0] OP_CONT_HF1 = 8'h1B;
  localparam logic [7:0] OP_CONT_OLD = 8'hE8;
  localparam logic [7:0] OP_BUF1_RD_LF = 8'hD1;
  localparam logic [7:0] OP_BUF2_RD_LF = 8'hD3;
  localparam logic [7:0] OP_BUF1_RD_HF = 8'hD4;
  localparam logic [7:0] OP_BUF2_RD_HF = 8'hD6;
  localparam logic [7:0] OP_BUF1_WR = 8'h84;
  localparam logic [7:0] OP_BUF2_WR = 8'h87;
  localparam logic [7:0] OP_B1_PGM_ERS = 8'h83;
  localparam logic [7:0] OP_B2_PGM_ERS = 8'h86;
  localparam logic [7:0] OP_B1_PGM_NOE = 8'h88;
  localparam logic [7:0] OP_B2_PGM_NOE = 8'h89;
  localparam logic [7:0] OP_THRU_B1_ERS = 8'h82;
  localparam logic [7:0] OP_THRU_B2_ERS = 8'h85;
  localparam logic [7:0] OP_THRU_B1_NOE = 8'h02;
  localparam logic [7:0] OP_PAGE_ERS = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERS = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERS = 8'h7C;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_PROT_RD = 8'h32;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77;
  localparam logic [7:0] OP_B1_XFER = 8'h53;
  localparam logic [7:0] OP_B2_XFER = 8'h55;
  localparam logic [7:0] OP_B1_CMP = 8'h60;
  localparam logic [7:0] OP_B2_CMP = 8'h61;
  localparam logic [7:0] OP_B1_REWR = 8'h58;
  localparam logic [7:0] OP_B2_REWR = 8'h59;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_DPD_EXIT = 8'hAB;
  localparam logic [7:0] OP_UDPD = 8'h79;
  localparam logic [7:0] OP_STATUS_RD = 8'hD7;
  localparam logic [7:0] OP_ID_RD = 8'h9F;
  localparam logic [7:0] OP_OLD_BUF1_RD = 8'h54;
  localparam logic [7:0] OP_OLD_BUF2_RD = 8'h56;
  localparam logic [7:0] OP_OLD_PAGE_RD = 8'h52;
  localparam logic [7:0] OP_OLD_CONT_RD = 8'h68;
  localparam logic [7:0] OP_OLD_STATUS = 8'h57;

  // ----------------------------------------------------------------
  // Four-byte sequences
  // ----------------------------------------------------------------
  localparam logic [7:0] SQ_ERS_0 = 8'hC7;
  localparam logic [7:0] SQ_ERS_1 = 8'h94;
  localparam logic [7:0] SQ_ERS_2 = 8'h80;
  localparam logic [7:0] SQ_ERS_3 = 8'h9A;
  localparam logic [7:0] SQ_PROT_0 = 8'h3D;
  localparam logic [7:0] SQ_PROT_1 = 8'h2A;
  localparam logic [7:0] SQ_PROT_2 = 8'h7F;
  localparam logic [7:0] SQ_PROT_EN = 8'hA9;
  localparam logic [7:0] SQ_PROT_DIS = 8'h9A;
  localparam logic [7:0] SQ_PROT_ERS = 8'hCF;
  localparam logic [7:0] SQ_PROT_PGM = 8'hFC;
  localparam logic [7:0] SQ_LOCKDOWN = 8'h30;
  localparam logic [7:0] SQ_FRZ_0 = 8'h34;
  localparam logic [7:0] SQ_FRZ_1 = 8'h55;
  localparam logic [7:0] SQ_FRZ_2 = 8'hAA;
  localparam logic [7:0] SQ_FRZ_3 = 8'h40;
  localparam logic [7:0] SQ_SEC_0 = 8'h9B;
  localparam logic [7:0] SQ_ZERO = 8'h00;

  localparam int BIT_COUNT_W = 3;
  localparam int BYTE_COUNT_W = 3;
  localparam logic [2:0] BYTE_SEQ_LAST = 3'h3;

  // ----------------------------------------------------------------
  // Command classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFCD_GRP_NONE = 3'h0,
    SFCD_GRP_READ = 3'h1,
    SFCD_GRP_TIMED = 3'h2,
    SFCD_GRP_LIGHT = 3'h3,
    SFCD_GRP_PROT = 3'h4,
    SFCD_GRP_CTRL = 3'h5
  } sfcd_grp_t;

  typedef enum logic [5:0] {
    SFCD_C_NONE, SFCD_C_PAGE_RD, SFCD_C_CONT_LP, SFCD_C_CONT_LF, SFCD_C_CONT_HF, SFCD_C_CONT_OLD,
    SFCD_C_BUF_RD_LF, SFCD_C_BUF_RD_HF, SFCD_C_PROT_RD, SFCD_C_LOCK_RD, SFCD_C_SEC_RD,
    SFCD_C_BUF_WR, SFCD_C_PGM_ERS, SFCD_C_PGM_NOE, SFCD_C_THRU_ERS, SFCD_C_THRU_NOE,
    SFCD_C_PAGE_ERS, SFCD_C_BLOCK_ERS, SFCD_C_SECTOR_ERS, SFCD_C_CHIP_ERS,
    SFCD_C_XFER, SFCD_C_CMP, SFCD_C_REWR, SFCD_C_SUSPEND, SFCD_C_RESUME,
    SFCD_C_PROT_EN, SFCD_C_PROT_DIS, SFCD_C_PROT_ERS, SFCD_C_PROT_PGM, SFCD_C_LOCKDOWN,
    SFCD_C_FREEZE, SFCD_C_SEC_PGM, SFCD_C_DPD, SFCD_C_DPD_EXIT, SFCD_C_UDPD,
    SFCD_C_STATUS_RD, SFCD_C_ID_RD
  } sfcd_cmd_t;

  // Decoded command as handed to the array engine.
  typedef struct packed {
    sfcd_cmd_t cmd;
    sfcd_grp_t grp;
    logic buf2;
    logic legacy;
    logic suspendable;
  } sfcd_dec_t;

endpackage : sfcd_pkg

// *** sfcd_opcode_lut.sv ***
// Single-byte opcode lookup for the serial flash command decoder.
`timescale 1ns/1ps
`default_nettype none
module sfcd_opcode_lut (
  input wire logic [7:0] opcode,
  output var sfcd_pkg::sfcd_dec_t dec,
  output logic multi_start
);

  function automatic sfcd_pkg::sfcd_dec_t mk(input sfcd_pkg::sfcd_cmd_t c, input sfcd_pkg::sfcd_grp_t g,
                                             input logic b2, input logic old, input logic sus);
    sfcd_pkg::sfcd_dec_t d;
    d.cmd = c;
    d.grp = g;
    d.buf2 = b2;
    d.legacy = old;
    d.suspendable = sus;
    return d;
  endfunction

  always_comb begin
    multi_start = 1'b0;
    dec = mk(sfcd_pkg::SFCD_C_NONE, sfcd_pkg::SFCD_GRP_NONE, 1'b0, 1'b0, 1'b0);
    case (opcode)
      sfcd_pkg::OP_PAGE_RD: dec = mk(sfcd_pkg::SFCD_C_PAGE_RD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R07
      sfcd_pkg::OP_CONT_LP: dec = mk(sfcd_pkg::SFCD_C_CONT_LP, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R07
      sfcd_pkg::OP_CONT_LF: dec = mk(sfcd_pkg::SFCD_C_CONT_LF, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R07
      sfcd_pkg::OP_CONT_HF0, sfcd_pkg::OP_CONT_HF1:
        dec = mk(sfcd_pkg::SFCD_C_CONT_HF, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R08
      sfcd_pkg::OP_CONT_OLD: dec = mk(sfcd_pkg::SFCD_C_CONT_OLD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b1, 1'b0); // R08
      sfcd_pkg::OP_BUF1_RD_LF: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_LF, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R09
      sfcd_pkg::OP_BUF2_RD_LF: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_LF, sfcd_pkg::SFCD_GRP_READ, 1'b1, 1'b0, 1'b0); // R09
      sfcd_pkg::OP_BUF1_RD_HF: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_HF, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R09
      sfcd_pkg::OP_BUF2_RD_HF: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_HF, sfcd_pkg::SFCD_GRP_READ, 1'b1, 1'b0, 1'b0); // R09
      sfcd_pkg::OP_PROT_RD: dec = mk(sfcd_pkg::SFCD_C_PROT_RD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R17
      sfcd_pkg::OP_LOCK_RD: dec = mk(sfcd_pkg::SFCD_C_LOCK_RD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R17
      sfcd_pkg::OP_SEC_RD: dec = mk(sfcd_pkg::SFCD_C_SEC_RD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b0, 1'b0); // R17
      sfcd_pkg::OP_BUF1_WR: dec = mk(sfcd_pkg::SFCD_C_BUF_WR, sfcd_pkg::SFCD_GRP_LIGHT, 1'b0, 1'b0, 1'b0); // R10
      sfcd_pkg::OP_BUF2_WR: dec = mk(sfcd_pkg::SFCD_C_BUF_WR, sfcd_pkg::SFCD_GRP_LIGHT, 1'b1, 1'b0, 1'b0); // R10
      sfcd_pkg::OP_B1_PGM_ERS: dec = mk(sfcd_pkg::SFCD_C_PGM_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R11
      sfcd_pkg::OP_B2_PGM_ERS: dec = mk(sfcd_pkg::SFCD_C_PGM_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b1); // R11
      sfcd_pkg::OP_B1_PGM_NOE: dec = mk(sfcd_pkg::SFCD_C_PGM_NOE, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R12
      sfcd_pkg::OP_B2_PGM_NOE: dec = mk(sfcd_pkg::SFCD_C_PGM_NOE, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b1); // R12
      sfcd_pkg::OP_THRU_B1_ERS: dec = mk(sfcd_pkg::SFCD_C_THRU_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R13
      sfcd_pkg::OP_THRU_B2_ERS: dec = mk(sfcd_pkg::SFCD_C_THRU_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b1); // R13
      sfcd_pkg::OP_THRU_B1_NOE: dec = mk(sfcd_pkg::SFCD_C_THRU_NOE, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R13
      sfcd_pkg::OP_PAGE_ERS: dec = mk(sfcd_pkg::SFCD_C_PAGE_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R14
      sfcd_pkg::OP_BLOCK_ERS: dec = mk(sfcd_pkg::SFCD_C_BLOCK_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R14
      sfcd_pkg::OP_SECTOR_ERS: dec = mk(sfcd_pkg::SFCD_C_SECTOR_ERS, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b1); // R14
      sfcd_pkg::OP_B1_XFER: dec = mk(sfcd_pkg::SFCD_C_XFER, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b0); // R19
      sfcd_pkg::OP_B2_XFER: dec = mk(sfcd_pkg::SFCD_C_XFER, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b0); // R19
      sfcd_pkg::OP_B1_CMP: dec = mk(sfcd_pkg::SFCD_C_CMP, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b0); // R19
      sfcd_pkg::OP_B2_CMP: dec = mk(sfcd_pkg::SFCD_C_CMP, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b0); // R19
      sfcd_pkg::OP_B1_REWR: dec = mk(sfcd_pkg::SFCD_C_REWR, sfcd_pkg::SFCD_GRP_TIMED, 1'b0, 1'b0, 1'b0); // R20
      sfcd_pkg::OP_B2_REWR: dec = mk(sfcd_pkg::SFCD_C_REWR, sfcd_pkg::SFCD_GRP_TIMED, 1'b1, 1'b0, 1'b0); // R20
      sfcd_pkg::OP_SUSPEND: dec = mk(sfcd_pkg::SFCD_C_SUSPEND, sfcd_pkg::SFCD_GRP_CTRL, 1'b0, 1'b0, 1'b0); // R05
      sfcd_pkg::OP_RESUME: dec = mk(sfcd_pkg::SFCD_C_RESUME, sfcd_pkg::SFCD_GRP_CTRL, 1'b0, 1'b0, 1'b0); // R05
      sfcd_pkg::OP_DPD: dec = mk(sfcd_pkg::SFCD_C_DPD, sfcd_pkg::SFCD_GRP_CTRL, 1'b0, 1'b0, 1'b0); // R21
      sfcd_pkg::OP_DPD_EXIT: dec = mk(sfcd_pkg::SFCD_C_DPD_EXIT, sfcd_pkg::SFCD_GRP_CTRL, 1'b0, 1'b0, 1'b0); // R21
      sfcd_pkg::OP_UDPD: dec = mk(sfcd_pkg::SFCD_C_UDPD, sfcd_pkg::SFCD_GRP_CTRL, 1'b0, 1'b0, 1'b0); // R21
      sfcd_pkg::OP_STATUS_RD: dec = mk(sfcd_pkg::SFCD_C_STATUS_RD, sfcd_pkg::SFCD_GRP_LIGHT, 1'b0, 1'b0, 1'b0); // R22
      sfcd_pkg::OP_ID_RD: dec = mk(sfcd_pkg::SFCD_C_ID_RD, sfcd_pkg::SFCD_GRP_LIGHT, 1'b0, 1'b0, 1'b0); // R22
      sfcd_pkg::OP_OLD_BUF1_RD: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_LF, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b1, 1'b0); // R22
      sfcd_pkg::OP_OLD_BUF2_RD: dec = mk(sfcd_pkg::SFCD_C_BUF_RD_LF, sfcd_pkg::SFCD_GRP_READ, 1'b1, 1'b1, 1'b0); // R22
      sfcd_pkg::OP_OLD_PAGE_RD: dec = mk(sfcd_pkg::SFCD_C_PAGE_RD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b1, 1'b0); // R22
      sfcd_pkg::OP_OLD_CONT_RD: dec = mk(sfcd_pkg::SFCD_C_CONT_OLD, sfcd_pkg::SFCD_GRP_READ, 1'b0, 1'b1, 1'b0); // R22
      sfcd_pkg::OP_OLD_STATUS: dec = mk(sfcd_pkg::SFCD_C_STATUS_RD, sfcd_pkg::SFCD_GRP_LIGHT, 1'b0, 1'b1, 1'b0); // R22
      sfcd_pkg::SQ_ERS_0, sfcd_pkg::SQ_PROT_0, sfcd_pkg::SQ_FRZ_0, sfcd_pkg::SQ_SEC_0: multi_start = 1'b1;
      default: ;
    endcase
  end

endmodule : sfcd_opcode_lut
`default_nettype wire

// *** sfcd_decoder.sv ***
// Top of the serial flash command decoder: SPI byte capture, sequences and concurrency gate.
//
// Summary of operation
// (R01) Host starts nothing while a read runs.
// (R02) Accept buffer write, status, ID while timed.
// (R03) Host writes only the idle buffer; the decoder accepts a buffer write to either buffer while timed.
// (R04) Only status read during protection timed phase.
// (R05) B0h suspends program/erase; D0h resumes them.
// (R06) All reads accepted while suspended.
// (R07) D2h page read, 01h and 03h continuous.
// (R08) 0Bh/1Bh fast continuous; E8h older read.
// (R09) Buffer reads D1h/D3h slow, D4h/D6h fast.
// (R10) 84h/87h write buffer one/two.
// (R11) 83h/86h buffer program with erase.
// (R12) 88h/89h buffer program without erase.
// (R13) 82h/85h program through buffer; 02h too.
// (R14) C7h,94h,80h,9Ah chip erase; 81h/50h/7Ch.
// (R15) 3Dh,2Ah,7Fh then A9h/9Ah protection on/off.
// (R16) Prefix then CFh/FCh/30h register ops.
// (R17) 32h/35h/77h read protection, lockdown, security.
// (R18) Freeze sequence and security program sequence.
// (R19) 53h/55h transfer, 60h/61h compare.
// (R20) 58h/59h automatic page rewrite.
// (R21) B9h/ABh deep power-down; 79h ultra-deep.
// (R22) D7h status, 9Fh ID, older opcodes kept.
`timescale 1ns/1ps
`default_nettype none
module sfcd_decoder (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  input wire logic op_busy,
  input wire logic op_done,
  output var sfcd_pkg::sfcd_dec_t cmd_out,
  output logic cmd_valid,
  output logic cmd_reject,
  output logic timed_busy,
  output logic suspended,
  output logic prot_busy,
  output logic read_active,
  output logic active_buf2,
  output logic deep_pd,
  output logic ultra_pd
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFCD_ENG_IDLE = 3'b001,
    SFCD_ENG_TIMED = 3'b010,
    SFCD_ENG_SUSP = 3'b100
  } sfcd_eng_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] si_sync;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] first;
    logic seq_ok;
    logic read_on;
    sfcd_eng_t eng;
    logic eng_susp_ok;
    logic eng_prot;
    logic eng_buf2;
    sfcd_pkg::sfcd_dec_t out;
    logic valid;
    logic reject;
    logic dpd;
    logic udpd;
  } sfcd_state_t;

  sfcd_state_t st_reg;
  sfcd_state_t st_next;
  sfcd_pkg::sfcd_dec_t lut_dec;
  logic lut_multi;
  logic [7:0] byte_now;

  sfcd_opcode_lut u_lut (
    .opcode(byte_now),
    .dec(lut_dec),
    .multi_start(lut_multi)
  );

  assign byte_now = {st_reg.shift[6:0], st_reg.si_sync[1]};

  // Second and third bytes of each four-byte sequence, keyed by its first byte.
  function automatic logic seq_byte_ok(input logic [7:0] first, input logic [2:0] idx, input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    unique case (first)
      sfcd_pkg::SQ_ERS_0: ok = (idx == 3'h1) ? (b == sfcd_pkg::SQ_ERS_1) : (b == sfcd_pkg::SQ_ERS_2);
      sfcd_pkg::SQ_PROT_0: ok = (idx == 3'h1) ? (b == sfcd_pkg::SQ_PROT_1) : (b == sfcd_pkg::SQ_PROT_2);
      sfcd_pkg::SQ_FRZ_0: ok = (idx == 3'h1) ? (b == sfcd_pkg::SQ_FRZ_1) : (b == sfcd_pkg::SQ_FRZ_2);
      sfcd_pkg::SQ_SEC_0: ok = (b == sfcd_pkg::SQ_ZERO);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Final byte of a four-byte sequence into a command descriptor.
  function automatic sfcd_pkg::sfcd_dec_t seq_final(input logic [7:0] first, input logic [7:0] b);
    sfcd_pkg::sfcd_dec_t d;
    d = '0;
    d.cmd = sfcd_pkg::SFCD_C_NONE;
    d.grp = sfcd_pkg::SFCD_GRP_PROT;
    unique case (first)
      sfcd_pkg::SQ_ERS_0: begin
        if (b == sfcd_pkg::SQ_ERS_3) begin
          d.cmd = sfcd_pkg::SFCD_C_CHIP_ERS; // R14
          d.grp = sfcd_pkg::SFCD_GRP_TIMED;
          d.suspendable = 1'b1;
        end
      end
      sfcd_pkg::SQ_PROT_0: begin
        unique case (b)
          sfcd_pkg::SQ_PROT_EN: d.cmd = sfcd_pkg::SFCD_C_PROT_EN; // R15
          sfcd_pkg::SQ_PROT_DIS: d.cmd = sfcd_pkg::SFCD_C_PROT_DIS; // R15
          sfcd_pkg::SQ_PROT_ERS: d.cmd = sfcd_pkg::SFCD_C_PROT_ERS; // R16
          sfcd_pkg::SQ_PROT_PGM: d.cmd = sfcd_pkg::SFCD_C_PROT_PGM; // R16
          sfcd_pkg::SQ_LOCKDOWN: d.cmd = sfcd_pkg::SFCD_C_LOCKDOWN; // R16
          default: d.cmd = sfcd_pkg::SFCD_C_NONE;
        endcase
      end
      sfcd_pkg::SQ_FRZ_0: begin
        if (b == sfcd_pkg::SQ_FRZ_3) begin
          d.cmd = sfcd_pkg::SFCD_C_FREEZE; // R18
        end
      end
      sfcd_pkg::SQ_SEC_0: begin
        if (b == sfcd_pkg::SQ_ZERO) begin
          d.cmd = sfcd_pkg::SFCD_C_SEC_PGM; // R18
        end
      end
      default: d.cmd = sfcd_pkg::SFCD_C_NONE;
    endcase
    if (d.cmd == sfcd_pkg::SFCD_C_NONE) begin
      d.grp = sfcd_pkg::SFCD_GRP_NONE;
    end
    return d;
  endfunction

  // Whether a decoded command may start in the present engine state.
  function automatic logic allowed(input sfcd_pkg::sfcd_dec_t d, input sfcd_eng_t eng, input logic prot,
                                   input logic susp_ok, input logic dpd);
    logic ok;
    ok = 1'b0;
    if (dpd) begin
      ok = (d.cmd == sfcd_pkg::SFCD_C_DPD_EXIT); // R21
    end else begin
      unique case (eng)
        SFCD_ENG_IDLE: ok = (d.cmd != sfcd_pkg::SFCD_C_RESUME) && (d.cmd != sfcd_pkg::SFCD_C_SUSPEND);
        SFCD_ENG_TIMED: begin
          if (prot) begin
            ok = (d.cmd == sfcd_pkg::SFCD_C_STATUS_RD); // R04
          end else begin
            ok = (d.grp == sfcd_pkg::SFCD_GRP_LIGHT) // R02
                 || ((d.cmd == sfcd_pkg::SFCD_C_SUSPEND) && susp_ok); // R05
          end
        end
        SFCD_ENG_SUSP: ok = (d.grp == sfcd_pkg::SFCD_GRP_READ) // R06
                            || (d.grp == sfcd_pkg::SFCD_GRP_LIGHT) || (d.cmd == sfcd_pkg::SFCD_C_RESUME); // R05
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic sck_rise;
  logic cs_open;
  logic byte_done;
  sfcd_pkg::sfcd_dec_t cand;
  logic cand_valid;

  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    st_next.reject = 1'b0;
    st_next.cs_sync = {st_reg.cs_sync[1:0], spi_cs_n};
    st_next.sck_sync = {st_reg.sck_sync[1:0], spi_sck};
    st_next.si_sync = {st_reg.si_sync[0], spi_si};
    // Only the second and third stages are read, so metastability settles first.
    sck_rise = st_reg.sck_sync[1] && !st_reg.sck_sync[2];
    cs_open = !st_reg.cs_sync[1];
    byte_done = cs_open && sck_rise && (st_reg.bit_cnt == 3'h7);
    cand = lut_dec;
    cand_valid = 1'b0;

    if (!cs_open) begin
      st_next.bit_cnt = '0;
      st_next.byte_cnt = '0;
      st_next.seq_ok = 1'b0;
      // A read ends only when chip select rises.
      st_next.read_on = 1'b0; // R01
    end else if (sck_rise) begin
      st_next.shift = byte_now;
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
    end

    if (byte_done && !st_reg.read_on) begin
      if (st_reg.byte_cnt == 3'h0) begin
        st_next.first = byte_now;
        st_next.seq_ok = lut_multi;
        st_next.byte_cnt = 3'h1;
        cand_valid = !lut_multi;
      end else if (st_reg.byte_cnt < sfcd_pkg::BYTE_SEQ_LAST) begin
        st_next.seq_ok = st_reg.seq_ok && seq_byte_ok(st_reg.first, st_reg.byte_cnt, byte_now);
        st_next.byte_cnt = st_reg.byte_cnt + 3'h1;
      end else if (st_reg.byte_cnt == sfcd_pkg::BYTE_SEQ_LAST) begin
        // Only a complete, exact sequence produces a command; anything else is dropped.
        cand = seq_final(st_reg.first, byte_now); // R14
        cand_valid = st_reg.seq_ok && (cand.cmd != sfcd_pkg::SFCD_C_NONE);
        st_next.byte_cnt = 3'h4;
      end
    end

    if (cand_valid && cand.cmd != sfcd_pkg::SFCD_C_NONE) begin
      if (allowed(cand, st_reg.eng, st_reg.eng_prot, st_reg.eng_susp_ok, st_reg.dpd)) begin
        st_next.out = cand;
        st_next.valid = 1'b1;
        st_next.read_on = (cand.grp == sfcd_pkg::SFCD_GRP_READ); // R01
        unique case (cand.cmd)
          sfcd_pkg::SFCD_C_SUSPEND: st_next.eng = SFCD_ENG_SUSP; // R05
          sfcd_pkg::SFCD_C_RESUME: st_next.eng = SFCD_ENG_TIMED; // R05
          sfcd_pkg::SFCD_C_DPD: st_next.dpd = 1'b1; // R21
          sfcd_pkg::SFCD_C_DPD_EXIT: st_next.dpd = 1'b0; // R21
          sfcd_pkg::SFCD_C_UDPD: st_next.udpd = 1'b1; // R21
          default: begin
            if (cand.grp == sfcd_pkg::SFCD_GRP_TIMED || cand.grp == sfcd_pkg::SFCD_GRP_PROT) begin
              st_next.eng = SFCD_ENG_TIMED;
              st_next.eng_prot = (cand.grp == sfcd_pkg::SFCD_GRP_PROT); // R04
              st_next.eng_susp_ok = cand.suspendable; // R05
              st_next.eng_buf2 = cand.buf2; // R03
            end
          end
        endcase
      end else begin
        st_next.reject = 1'b1;
      end
    end

    // Completion from the array engine; a suspended operation cannot finish.
    if (op_done && st_reg.eng == SFCD_ENG_TIMED) begin
      st_next.eng = SFCD_ENG_IDLE;
      st_next.eng_prot = 1'b0;
      st_next.eng_susp_ok = 1'b0;
    end
    // Ultra-deep power-down is left only by a reset, since no opcode wakes it.
    if (st_reg.udpd) begin
      st_next.valid = 1'b0;
      st_next.reject = 1'b0;
      st_next.eng = st_reg.eng;
      st_next.out = st_reg.out;
      st_next.udpd = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.cs_sync <= 3'h7;
      st_reg.eng <= SFCD_ENG_IDLE;
      st_reg.out.cmd <= sfcd_pkg::SFCD_C_NONE;
      st_reg.out.grp <= sfcd_pkg::SFCD_GRP_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_out = st_reg.out;
  assign cmd_valid = st_reg.valid;
  assign cmd_reject = st_reg.reject;
  assign timed_busy = (st_reg.eng == SFCD_ENG_TIMED) || op_busy;
  assign suspended = (st_reg.eng == SFCD_ENG_SUSP);
  assign prot_busy = st_reg.eng_prot;
  assign read_active = st_reg.read_on;
  assign active_buf2 = st_reg.eng_buf2;
  assign deep_pd = st_reg.dpd;
  assign ultra_pd = st_reg.udpd;

endmodule : sfcd_decoder
`default_nettype wire

// *** sfcd_decoder_props.sv ***
// Checker for the serial flash command decoder outputs.
`timescale 1ns/1ps
`default_nettype none
module sfcd_decoder_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sfcd_pkg::sfcd_dec_t cmd_out,
  input wire logic cmd_valid,
  input wire logic cmd_reject,
  input wire logic timed_busy,
  input wire logic suspended,
  input wire logic prot_busy,
  input wire logic deep_pd,
  input wire logic ultra_pd
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_excl; cmd_valid |-> !cmd_reject; endproperty
  a_excl: assert property (p_excl) else $error("valid with reject");
  property p_pulse; cmd_valid |=> !cmd_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_hold; $changed(cmd_out) |-> cmd_valid; endproperty
  a_hold: assert property (p_hold) else $error("command changed without accept");
  property p_prot; cmd_valid && $past(prot_busy) |-> cmd_out.cmd == sfcd_pkg::SFCD_C_STATUS_RD; endproperty
  a_prot: assert property (p_prot) else $error("non-status accepted in protection phase");
  property p_timed; cmd_valid && $past(timed_busy) && !$past(suspended) && !$past(prot_busy) |->
    cmd_out.grp == sfcd_pkg::SFCD_GRP_LIGHT || cmd_out.cmd == sfcd_pkg::SFCD_C_SUSPEND; endproperty
  a_timed: assert property (p_timed) else $error("wrong command accepted while timed");
  property p_dpd; cmd_valid && $past(deep_pd) |-> cmd_out.cmd == sfcd_pkg::SFCD_C_DPD_EXIT; endproperty
  a_dpd: assert property (p_dpd) else $error("command accepted in power-down");
  property p_udpd; ultra_pd |=> ultra_pd && !cmd_valid && !cmd_reject; endproperty
  a_udpd: assert property (p_udpd) else $error("activity in ultra-deep power-down");
  property p_susp; cmd_valid && cmd_out.cmd == sfcd_pkg::SFCD_C_SUSPEND |-> ##[0:2] suspended; endproperty
  a_susp: assert property (p_susp) else $error("suspend not taken");
endmodule // sfcd_decoder_props
bind sfcd_decoder sfcd_decoder_props sfcd_decoder_props_inst (.core_clk, .rst_n, .cmd_out, .cmd_valid,
  .cmd_reject, .timed_busy, .suspended, .prot_busy, .deep_pd, .ultra_pd);
`default_nettype wire

// *** sfcd_spi_host.sv ***
// SPI host model that frames flash commands, mode 0.
`timescale 1ns/1ps
`default_nettype none
module sfcd_spi_host (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Whole command per frame; the caller waits for the answer before the next one.
  task automatic xfer(input logic [31:0] d, input int n);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 32 - 8 * n; i--) begin
      spi_si = d[i];
      tick(4);
      spi_sck = 1'b1;
      tick(4);
      spi_sck = 1'b0;
    end
    tick(4);
    spi_cs_n = 1'b1;
    // Outside a frame the data line carries nothing, so it flips instead of holding.
    spi_si = ~spi_si;
    tick(8);
  endtask
endmodule // sfcd_spi_host
`default_nettype wire

// *** sfcd_decoder_tb.sv ***
// Self-checking testbench for the serial flash command decoder.
`timescale 1ns/1ps
`default_nettype none
module sfcd_decoder_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_busy = 1'b0;
  logic op_done = 1'b0;
  wire logic spi_cs_n, spi_sck, spi_si;
  sfcd_pkg::sfcd_dec_t cmd_out;
  logic cmd_valid, cmd_reject, timed_busy, suspended, prot_busy, read_active, active_buf2, deep_pd, ultra_pd;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] nv = 8'h0;
  logic [7:0] nr = 8'h0;
  // Low byte of each entry is {buffer two, 0, expected command code}.
  logic [15:0] one [0:33] = '{16'hD201, 16'h0102, 16'h0303, 16'h0B04, 16'h1B04, 16'hE805, 16'hD106, 16'hD386,
    16'hD407, 16'hD687, 16'h3208, 16'h3509, 16'h770A, 16'h840B, 16'h878B, 16'h830C, 16'h868C, 16'h880D,
    16'h898D, 16'h820E, 16'h858E, 16'h020F, 16'h8110, 16'h5011, 16'h7C12, 16'h5314, 16'h5594, 16'h6015,
    16'h6195, 16'h5816, 16'h5996, 16'hD723, 16'h9F24, 16'h5723};
  // The first sequence is broken, so the last command must stay in place.
  logic [39:0] seq [0:8] = '{40'hC794809B23, 40'hC794809A13, 40'h3D2A7FA919, 40'h3D2A7F9A1A,
    40'h3D2A7FCF1B, 40'h3D2A7FFC1C, 40'h3D2A7F301D, 40'h3455AA401E, 40'h9B0000001F};
  always #2.5 core_clk = ~core_clk;
  sfcd_decoder sfcd_decoder_inst (.core_clk, .rst_n, .spi_cs_n, .spi_sck, .spi_si, .op_busy, .op_done,
    .cmd_out, .cmd_valid, .cmd_reject, .timed_busy, .suspended, .prot_busy, .read_active, .active_buf2,
    .deep_pd, .ultra_pd);
  sfcd_spi_host sfcd_spi_host_inst (.core_clk, .spi_cs_n, .spi_sck, .spi_si);
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) nv <= nv + 8'h1;
    if (cmd_reject === 1'b1) nr <= nr + 8'h1;
    if (cycles == 50000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] d, input int n, input logic [1:0] e);
    nv = 8'h0;
    nr = 8'h0;
    sfcd_spi_host_inst.xfer(d, n);
    chk({nv[3:0], nr[3:0]}, {3'h0, e[1], 3'h0, e[0]});
  endtask
  task automatic done_op();
    op_done = 1'b1;
    @(posedge core_clk);
    #1 op_done = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk({7'h0, timed_busy}, 8'h0);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 34; i++) begin
      cmd({one[i][15:8], 24'h0}, 1, 2'h2);
      chk({cmd_out.buf2, 1'b0, cmd_out.cmd}, one[i][7:0]);
      if (timed_busy === 1'b1) chk({7'h0, active_buf2}, {7'h0, one[i][7]});
      if ((timed_busy | prot_busy) === 1'b1) done_op();
    end
    for (int i = 0; i < 9; i++) begin
      cmd(seq[i][39:8], 4, (i == 0) ? 2'h0 : 2'h2);
      chk({cmd_out.buf2, 1'b0, cmd_out.cmd}, seq[i][7:0]);
      if ((timed_busy | prot_busy) === 1'b1) done_op();
    end
  endtask
  task automatic t_conc();
    cmd(32'h83000000, 1, 2'h2);
    op_busy = 1'b1;
    cmd(32'h87000000, 1, 2'h2);
    cmd(32'hD7000000, 1, 2'h2);
    cmd(32'hD2000000, 1, 2'h1);
    cmd(32'hB0000000, 1, 2'h2);
    chk({7'h0, suspended}, 8'h1);
    cmd(32'hD2000000, 1, 2'h2);
    chk({7'h0, read_active}, 8'h0);
    cmd(32'hD0000000, 1, 2'h2);
    chk({7'h0, suspended}, 8'h0);
    op_busy = 1'b0;
    done_op();
    cmd(32'hB0000000, 1, 2'h1);
    cmd(32'h53000000, 1, 2'h2);
    cmd(32'hB0000000, 1, 2'h1);
    done_op();
    cmd(32'h3D2A7FCF, 4, 2'h2);
    chk({7'h0, prot_busy}, 8'h1);
    cmd(32'h87000000, 1, 2'h1);
    cmd(32'hD7000000, 1, 2'h2);
    done_op();
  endtask
  task automatic t_power();
    cmd(32'hB9000000, 1, 2'h2);
    chk({7'h0, deep_pd}, 8'h1);
    cmd(32'hAB000000, 1, 2'h2);
    chk({7'h0, deep_pd}, 8'h0);
    cmd(32'h79000000, 1, 2'h2);
    cmd(32'hD7000000, 1, 2'h0);
    chk({7'h0, ultra_pd}, 8'h1);
  endtask
  task automatic test_done();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_codes();
    t_conc();
    t_power();
    test_done();
  end
endmodule // sfcd_decoder_tb
`default_nettype wire
